// ==== hw/eepc_loader.sv ====
// Configuration image loader: header parse, descriptor check and fetch
//
// Contract
// - The image counts as programmed only if byte 00h is a5h.
// - Bytes 01h to 06h form the station address in address order.
// - Byte 07h is the full-speed interrupt polling interval.
// - Byte 08h is the high-speed interrupt polling interval.
// - Byte 09h is the configuration flags byte.
// - Bytes 0ah and 0bh give the language id, low byte first.
// - Bytes 0ch to 15h hold five string length/word offset pairs.
// - A stored word offset is doubled to give the byte address.
// - A zero length marks a descriptor absent; its offset is unused.
// - Bytes 16h to 1dh hold four device/config length/offset pairs.
// - Bytes 1eh and 1fh give wake enables for pins 7:0 and 10:8.
// - Byte 20h is the wake signalling flags byte.
// - Byte 21h is padding and is never used.
// - A string descriptor starts with its size, then type 03h.
// - Without the signature, loading stops and defaults remain.
// - The USB attachment stays disconnected until loading ends.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module eepc_loader
  import eepc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // EEPROM byte reader
  output eepc_ee_req_t     ee_req,
  input  wire logic        ee_ack,
  input  wire logic [7:0]  ee_rdata,
  // Loaded configuration
  output eepc_cfg_t        cfg,
  output logic             image_valid,
  output logic             load_done,
  output logic             usb_disconnect
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (int'(HDR_PTR0) + 2 * NUM_PTR != int'(HDR_WAKE_LO)) begin : g_bad_map
    $error("pointer table does not end at the wake enable bytes");
  end
  if (NUM_STR > NUM_PTR || HDR_BYTES != int'(HDR_PAD)) begin : g_bad_cnt
    $error("header byte or pointer counts inconsistent");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  eepc_state_t        state_q;
  logic [7:0]         hdr_q [HDR_BYTES];
  logic [5:0]         hdr_idx_q;
  logic [2:0]         chk_idx_q;
  logic               chk_half_q;
  logic [NUM_STR-1:0] str_fail_q;
  logic               prog_q;
  logic               done_q;
  logic [3:0]         dsel_q;
  logic [7:0]         didx_q;
  logic [7:0]         ddata_q;
  logic               dvalid_q;
  logic               derr_q;
  logic [31:0]        prdata_q;
  logic               pslverr_q;

  eepc_ptr_t          ptr [NUM_PTR];
  logic [NUM_PTR-1:0] present;
  eepc_ptr_t          chk_ptr;
  eepc_ptr_t          new_ptr;
  eepc_ptr_t          cur_ptr;
  logic               apb_wr;
  logic               reload_req;
  logic               fetch_req;
  logic               fetch_ok;
  logic               sig_bad;
  logic [31:0]        rd_data;
  logic               rd_err;

  // ----------------------------------------------------------------
  // Pointer decode
  // ----------------------------------------------------------------
  // Pairs 0-4 are strings, 5-8 device and configuration descriptors
  for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
    eepc_ptr_dec u_dec (
      .len_byte  (hdr_q[int'(HDR_PTR0) + 2 * i]),
      .woff_byte (hdr_q[int'(HDR_PTR0) + 2 * i + 1]),
      .ptr       (ptr[i])
    );
    assign present[i] = ptr[i].present;
  end

  // Out-of-range selects give an absent pointer, not an X
  function automatic eepc_ptr_t ptr_pick(input logic [3:0] sel);
    eepc_ptr_t p;
    p = '0;
    for (int k = 0; k < NUM_PTR; k++) begin
      if (sel == 4'(k)) begin
        p = ptr[k];
      end
    end
    return p;
  endfunction : ptr_pick

  // A process, not an assign: the function reads the decoded table
  always_comb begin
    chk_ptr = ptr_pick({1'b0, chk_idx_q});
    new_ptr = ptr_pick(pwdata[3:0]);
    cur_ptr = ptr_pick(dsel_q);
  end

  // ----------------------------------------------------------------
  // APB strobes
  // ----------------------------------------------------------------
  // Zero wait states; read data is captured in the setup cycle
  assign pready     = 1'b1;
  assign prdata     = prdata_q;
  assign pslverr    = pslverr_q;
  assign apb_wr     = psel & penable & pwrite;
  assign reload_req = apb_wr & (paddr == REG_CTRL) & pwdata[CTRL_RELOAD];
  assign fetch_req  = apb_wr & (paddr == REG_DSEL);
  assign sig_bad    = (hdr_idx_q == HDR_SIG) && (ee_rdata != SIG_VALUE);

  // Descriptors only after the whole header was parsed
  assign fetch_ok = (state_q == ST_READY) && prog_q
                    && new_ptr.present
                    && (pwdata[DSEL_IDX_LSB +: 8] < new_ptr.len);

  // ----------------------------------------------------------------
  // EEPROM request
  // ----------------------------------------------------------------
  always_comb begin
    ee_req = '0;
    case (state_q)
      ST_HDR: begin
        ee_req.req  = 1'b1;
        ee_req.addr = {3'b000, hdr_idx_q};
      end
      ST_CHECK: begin
        ee_req.req  = chk_ptr.present;
        ee_req.addr = chk_ptr.base + {8'h00, chk_half_q};
      end
      ST_FETCH: begin
        ee_req.req  = 1'b1;
        ee_req.addr = cur_ptr.base + {1'b0, didx_q};
      end
      default: begin
        ee_req = '0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Load sequence
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ST_HDR;
      hdr_idx_q  <= 6'h00;
      chk_idx_q  <= 3'h0;
      chk_half_q <= 1'b0;
      prog_q     <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      case (state_q)
        ST_HDR: begin
          if (ee_ack) begin
            if (sig_bad) begin
              state_q <= ST_READY;
              done_q  <= 1'b1;
            end else if (hdr_idx_q == HDR_PME) begin
              // Pad byte follows; it is never fetched
              state_q    <= ST_CHECK;
              prog_q     <= 1'b1;
              chk_idx_q  <= 3'h0;
              chk_half_q <= 1'b0;
            end else begin
              hdr_idx_q <= hdr_idx_q + 6'h01;
            end
          end
        end
        ST_CHECK: begin
          if (!chk_ptr.present || ee_ack) begin
            if (chk_ptr.present && !chk_half_q) begin
              chk_half_q <= 1'b1;
            end else begin
              chk_half_q <= 1'b0;
              if (chk_idx_q == 3'(NUM_STR - 1)) begin
                state_q <= ST_READY;
                done_q  <= 1'b1;
              end else begin
                chk_idx_q <= chk_idx_q + 3'h1;
              end
            end
          end
        end
        ST_READY: begin
          if (reload_req) begin
            state_q   <= ST_HDR;
            hdr_idx_q <= 6'h00;
            prog_q    <= 1'b0;
            done_q    <= 1'b0;
          end else if (fetch_req && fetch_ok) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (ee_ack) begin
            state_q <= ST_READY;
          end
        end
        default: begin
          state_q <= ST_HDR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Header byte store
  // ----------------------------------------------------------------
  // A reload wipes old contents so a failed image leaves defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < HDR_BYTES; k++) begin
        hdr_q[k] <= 8'h00;
      end
    end else if (state_q == ST_READY && reload_req) begin
      for (int k = 0; k < HDR_BYTES; k++) begin
        hdr_q[k] <= 8'h00;
      end
    end else if (state_q == ST_HDR && ee_ack && !sig_bad) begin
      hdr_q[hdr_idx_q] <= ee_rdata;
    end
  end

  // ----------------------------------------------------------------
  // String descriptor check
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      str_fail_q <= '0;
    end else if (state_q == ST_READY && reload_req) begin
      str_fail_q <= '0;
    end else if (state_q == ST_CHECK && chk_ptr.present && ee_ack) begin
      if (!chk_half_q && ee_rdata != chk_ptr.len) begin
        str_fail_q[chk_idx_q] <= 1'b1;
      end
      if (chk_half_q && ee_rdata != STR_TYPE) begin
        str_fail_q[chk_idx_q] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Descriptor byte fetch
  // ----------------------------------------------------------------
  // A refused fetch starts no request and sets the error flag; outside ST_FETCH it also stores select and index and clears valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsel_q   <= 4'h0;
      didx_q   <= 8'h00;
      ddata_q  <= 8'h00;
      dvalid_q <= 1'b0;
      derr_q   <= 1'b0;
    end else if (fetch_req && state_q != ST_FETCH) begin
      dsel_q   <= pwdata[3:0];
      didx_q   <= pwdata[DSEL_IDX_LSB +: 8];
      dvalid_q <= 1'b0;
      derr_q   <= !fetch_ok;
    end else if (fetch_req) begin
      derr_q <= 1'b1;
    end else if (state_q == ST_FETCH && ee_ack) begin
      ddata_q  <= ee_rdata;
      dvalid_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  assign cfg.station_addr = {hdr_q[HDR_MAC0],
                             hdr_q[HDR_MAC0 + 6'd1],
                             hdr_q[HDR_MAC0 + 6'd2],
                             hdr_q[HDR_MAC0 + 6'd3],
                             hdr_q[HDR_MAC0 + 6'd4],
                             hdr_q[HDR_MAC0 + 6'd5]};
  assign cfg.fs_interval  = hdr_q[HDR_FS_IVL];
  assign cfg.hs_interval  = hdr_q[HDR_HS_IVL];
  assign cfg.cfg_flags    = hdr_q[HDR_FLAGS];
  assign cfg.lang_id      = {hdr_q[HDR_LANG_HI],
                             hdr_q[HDR_LANG_LO]};
  assign cfg.gpio_wake_en = {hdr_q[HDR_WAKE_HI][2:0],
                             hdr_q[HDR_WAKE_LO]};
  assign cfg.pme_flags    = hdr_q[HDR_PME];

  assign load_done      = done_q;
  assign image_valid    = done_q & prog_q;
  // Host must not see the device before its descriptors exist
  assign usb_disconnect = !done_q;

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (paddr)
      REG_CTRL: begin
        rd_data = 32'h0000_0000;
      end
      REG_STATUS: begin
        rd_data[STAT_DONE] = done_q;
        rd_data[STAT_PROG] = prog_q;
        rd_data[STAT_BUSY] = (state_q != ST_READY);
        rd_data[STAT_STRFAIL_LSB +: NUM_STR] = str_fail_q;
        rd_data[STAT_PRESENT_LSB +: NUM_PTR] = present;
      end
      REG_MAC_LO: begin
        rd_data = cfg.station_addr[31:0];
      end
      REG_MAC_HI: begin
        rd_data[15:0] = cfg.station_addr[47:32];
      end
      REG_IVL: begin
        rd_data[23:0] = {cfg.cfg_flags, cfg.hs_interval, cfg.fs_interval};
      end
      REG_LANG: begin
        rd_data[15:0] = cfg.lang_id;
      end
      REG_WAKE: begin
        rd_data[10:0]  = cfg.gpio_wake_en;
        rd_data[23:16] = cfg.pme_flags;
      end
      REG_DSEL: begin
        rd_data[3:0]                 = dsel_q;
        rd_data[DSEL_IDX_LSB +: 8]   = didx_q;
      end
      REG_DDATA: begin
        rd_data[7:0]        = ddata_q;
        rd_data[DDATA_VALID] = dvalid_q;
        rd_data[DDATA_ERR]   = derr_q;
      end
      default: begin
        rd_err = 1'b1;
        for (int k = 0; k < NUM_PTR; k++) begin
          if (paddr == REG_PTR0 + 12'(4 * k)) begin
            rd_err                         = 1'b0;
            rd_data[7:0]                   = ptr[k].len;
            rd_data[PTR_ADDR_LSB +: EE_AW] = ptr[k].base;
            rd_data[PTR_PRESENT]           = ptr[k].present;
          end
        end
      end
    endcase
  end

  // Captured in setup so prdata comes from flip-flops in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr_q <= rd_err;
    end
  end

endmodule : eepc_loader
`default_nettype wire

// ==== hw/eepc_pkg.sv ====
// Constants and types shared by the configuration image loader
package eepc_pkg;

  // ----------------------------------------------------------------
  // Image layout
  // ----------------------------------------------------------------
  localparam int         EE_AW       = 9;
  localparam logic [7:0] SIG_VALUE   = 8'ha5;
  localparam logic [7:0] STR_TYPE    = 8'h03;
  localparam logic [5:0] HDR_SIG     = 6'h00;
  localparam logic [5:0] HDR_MAC0    = 6'h01;
  localparam logic [5:0] HDR_FS_IVL  = 6'h07;
  localparam logic [5:0] HDR_HS_IVL  = 6'h08;
  localparam logic [5:0] HDR_FLAGS   = 6'h09;
  localparam logic [5:0] HDR_LANG_LO = 6'h0a;
  localparam logic [5:0] HDR_LANG_HI = 6'h0b;
  localparam logic [5:0] HDR_PTR0    = 6'h0c;
  localparam logic [5:0] HDR_WAKE_LO = 6'h1e;
  localparam logic [5:0] HDR_WAKE_HI = 6'h1f;
  localparam logic [5:0] HDR_PME     = 6'h20;
  localparam logic [5:0] HDR_PAD     = 6'h21;
  localparam int         HDR_BYTES   = 33;
  localparam int         NUM_PTR     = 9;
  localparam int         NUM_STR     = 5;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_MAC_LO = 12'h008;
  localparam logic [11:0] REG_MAC_HI = 12'h00c;
  localparam logic [11:0] REG_IVL    = 12'h010;
  localparam logic [11:0] REG_LANG   = 12'h014;
  localparam logic [11:0] REG_WAKE   = 12'h018;
  localparam logic [11:0] REG_DSEL   = 12'h01c;
  localparam logic [11:0] REG_DDATA  = 12'h020;
  localparam logic [11:0] REG_PTR0   = 12'h024;

  localparam int CTRL_RELOAD      = 0;
  localparam int STAT_DONE        = 0;
  localparam int STAT_PROG        = 1;
  localparam int STAT_BUSY        = 2;
  localparam int STAT_STRFAIL_LSB = 8;
  localparam int STAT_PRESENT_LSB = 16;
  localparam int DSEL_IDX_LSB     = 8;
  localparam int DDATA_VALID      = 8;
  localparam int DDATA_ERR        = 9;
  localparam int PTR_ADDR_LSB     = 16;
  localparam int PTR_PRESENT      = 31;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [47:0] station_addr;
    logic [7:0]  fs_interval;
    logic [7:0]  hs_interval;
    logic [7:0]  cfg_flags;
    logic [15:0] lang_id;
    logic [10:0] gpio_wake_en;
    logic [7:0]  pme_flags;
  } eepc_cfg_t;

  typedef struct packed {
    logic             req;
    logic [EE_AW-1:0] addr;
  } eepc_ee_req_t;

  typedef struct packed {
    logic             present;
    logic [EE_AW-1:0] base;
    logic [7:0]       len;
  } eepc_ptr_t;

  typedef enum logic [1:0] {
    ST_HDR,
    ST_CHECK,
    ST_READY,
    ST_FETCH
  } eepc_state_t;

endpackage : eepc_pkg

// ==== hw/eepc_ptr_dec.sv ====
// Descriptor pointer decoder: length and word offset to byte region
`timescale 1ns/1ps
`default_nettype none
module eepc_ptr_dec
  import eepc_pkg::*;
(
  // Stored pair
  input  wire logic [7:0] len_byte,
  input  wire logic [7:0] woff_byte,
  // Decoded region
  output eepc_ptr_t       ptr
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    ptr         = '0;
    ptr.len     = len_byte;
    ptr.present = (len_byte != 8'h00);
    // Offset is ignored for an absent descriptor
    if (ptr.present) begin
      ptr.base = {woff_byte, 1'b0};
    end
  end

endmodule : eepc_ptr_dec
`default_nettype wire

// ==== sim/eepc_ee_model.sv ====
// Behavioural serial configuration memory answering byte read requests
`timescale 1ns/1ps
`default_nettype none
module eepc_ee_model
  import eepc_pkg::*;
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Byte read port
  input  wire eepc_ee_req_t ee_req,
  input  wire logic         slow,
  output logic              ee_ack,
  output logic [7:0]        ee_rdata
);
  logic [7:0] mem [0:511];
  int         wait_q;

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  // Data inverts while idle so a late sample never sees the old byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_ack   <= 1'b0;
      ee_rdata <= 8'h00;
      wait_q   <= 0;
    end else if (ee_req.req && !ee_ack && wait_q >= (slow ? 3 : 0)) begin
      ee_ack   <= 1'b1;
      ee_rdata <= mem[ee_req.addr];
      wait_q   <= 0;
    end else begin
      ee_ack   <= 1'b0;
      ee_rdata <= ~ee_rdata;
      if (ee_req.req && !ee_ack) begin
        wait_q <= wait_q + 1;
      end
    end
  end
endmodule : eepc_ee_model
`default_nettype wire

// ==== sim/eepc_loader_asserts.sv ====
// Port checker for the configuration image loader
`timescale 1ns/1ps
`default_nettype none
module eepc_loader_asserts
  import eepc_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire eepc_ee_req_t ee_req,
  input wire logic         ee_ack,
  input wire logic [7:0]   ee_rdata,
  input wire eepc_cfg_t    cfg,
  input wire logic         image_valid,
  input wire logic         load_done,
  input wire logic         usb_disconnect
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Load handshake and header capture
  // ----------------------------------------------------------------
  sequence s_hdr(logic [8:0] a);
    ee_req.req && ee_ack && ee_req.addr == a && !load_done;
  endsequence

  a_disc_hold: assert property (!load_done |-> usb_disconnect)
    else $error("attach released before load finished");
  a_valid_done: assert property (image_valid |-> load_done)
    else $error("image valid before load finished");
  a_req_stable: assert property (ee_req.req && !ee_ack |=>
    ee_req.req && $stable(ee_req.addr))
    else $error("byte request dropped or moved before ack");
  a_sig_stop: assert property (s_hdr(9'h000) ##0 ee_rdata != SIG_VALUE
    |-> ##[1:8] load_done && !image_valid)
    else $error("bad signature did not end the load");
  a_mac_first: assert property (s_hdr({3'h0, HDR_MAC0})
    |=> cfg.station_addr[47:40] == $past(ee_rdata))
    else $error("first address byte not in top octet");
  a_lang_low: assert property (s_hdr({3'h0, HDR_LANG_LO})
    |=> cfg.lang_id[7:0] == $past(ee_rdata))
    else $error("language low byte misplaced");
  a_wake_high: assert property (s_hdr({3'h0, HDR_WAKE_HI})
    |=> cfg.gpio_wake_en[10:8] == $past(ee_rdata[2:0]))
    else $error("upper wake enables misplaced");
  a_pme_byte: assert property (s_hdr({3'h0, HDR_PME})
    |=> cfg.pme_flags == $past(ee_rdata))
    else $error("wake flags byte not captured");
  a_pad_skip: assert property (s_hdr({3'h0, HDR_PME})
    |=> ee_req.addr != {3'h0, HDR_PAD})
    else $error("padding byte was requested");
endmodule : eepc_loader_asserts
`default_nettype wire

bind eepc_loader eepc_loader_asserts eepc_loader_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ee_req(ee_req), .ee_ack(ee_ack),
  .ee_rdata(ee_rdata), .cfg(cfg), .image_valid(image_valid),
  .load_done(load_done), .usb_disconnect(usb_disconnect)
);

// ==== sim/tb_eepc_loader.sv ====
// Self-checking bench for the configuration image loader
`timescale 1ns/1ps
`default_nettype none
module tb_eepc_loader
  import eepc_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, d;
  logic         e, slow, image_valid, load_done, usb_disconnect, ee_ack;
  logic [7:0]   ee_rdata;
  eepc_ee_req_t ee_req;
  eepc_cfg_t    cfg;
  int           mismatches, comparisons;
  localparam logic [7:0] HDR [0:33] = '{8'ha5, 8'h12, 8'h34, 8'h56, 8'h78,
    8'h9a, 8'hbc, 8'h01, 8'h04, 8'h04, 8'h09, 8'h04, 8'h0a, 8'h11, 8'h12,
    8'h16, 8'h10, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h12, 8'h27, 8'h12,
    8'h30, 8'h12, 8'h39, 8'h12, 8'h42, 8'h00, 8'h04, 8'h8a, 8'h00};
  // Fetch cases: select, index, accepted, expected byte
  localparam logic [23:0] FT [0:6] = '{24'h101103, 24'h00010a, 24'h50014e,
    24'h20f14d, 24'h300000, 24'h900000, 24'h00a000};

  eepc_loader eepc_loader_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ee_req(ee_req),
    .ee_ack(ee_ack), .ee_rdata(ee_rdata), .cfg(cfg),
    .image_valid(image_valid), .load_done(load_done),
    .usb_disconnect(usb_disconnect));
  eepc_ee_model eepc_ee_model_inst (.pclk(pclk), .presetn(presetn),
    .ee_req(ee_req), .slow(slow), .ee_ack(ee_ack), .ee_rdata(ee_rdata));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [127:0] x,
                     input logic [127:0] g);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wait_load();
    for (int n = 0; n < 400; n++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (d[STAT_DONE] === 1'b1 && d[STAT_BUSY] === 1'b0) break;
    end
    chk("load finished", 1, d[STAT_DONE]);
  endtask : wait_load

  function automatic logic [31:0] ptr_exp(int i);
    logic [7:0] l, w;
    l = HDR[12 + 2 * i];
    w = HDR[13 + 2 * i];
    return (l == 8'h00) ? 32'h0 : {1'b1, 6'h00, w, 1'b0, 8'h00, l};
  endfunction : ptr_exp

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Loads take a few hundred cycles; this leaves wide margin
  initial begin
    #200us;
    mismatches++;
    stop_test();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; slow = 1'b0;
    mismatches = 0; comparisons = 0;
    for (int i = 0; i < 512; i++) eepc_ee_model_inst.mem[i] = i[7:0];
    for (int i = 0; i < 34; i++) eepc_ee_model_inst.mem[i] = HDR[i];
    for (int j = 0; j < 3; j++) begin
      eepc_ee_model_inst.mem[{HDR[13 + 2 * j], 1'b0}] = HDR[12 + 2 * j];
      eepc_ee_model_inst.mem[{HDR[13 + 2 * j], 1'b1}] = STR_TYPE;
    end
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("disconnect early", 1, usb_disconnect);
    wait_load();
    chk("disconnect after", 0, usb_disconnect);
    chk("image_valid", 1, image_valid);
    chk("station_addr", 48'h123456789abc, cfg.station_addr);
    chk("fs_interval", 8'h01, cfg.fs_interval);
    chk("hs_interval", 8'h04, cfg.hs_interval);
    chk("cfg_flags", 8'h04, cfg.cfg_flags);
    chk("lang_id", 16'h0409, cfg.lang_id);
    chk("gpio_wake_en", 11'h400, cfg.gpio_wake_en);
    chk("pme_flags", 8'h8a, cfg.pme_flags);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h01e70003, d);
    apb(1'b0, REG_MAC_LO, 32'h0);
    chk("mac_lo", 32'h56789abc, d);
    apb(1'b0, REG_MAC_HI, 32'h0);
    chk("mac_hi", 32'h00001234, d);
    apb(1'b0, REG_IVL, 32'h0);
    chk("ivl", 32'h00040401, d);
    apb(1'b0, REG_LANG, 32'h0);
    chk("lang", 32'h00000409, d);
    apb(1'b0, REG_WAKE, 32'h0);
    chk("wake", 32'h008a0400, d);
    for (int i = 0; i < NUM_PTR; i++) begin
      apb(1'b0, REG_PTR0 + 12'(4 * i), 32'h0);
      chk("ptr", ptr_exp(i), d);
    end
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, REG_DSEL, {16'h0, FT[k][19:12], 4'h0, FT[k][23:20]});
      for (int n = 0; n < 40; n++) begin
        apb(1'b0, REG_DDATA, 32'h0);
        if (d[DDATA_VALID] === 1'b1 || d[DDATA_ERR] === 1'b1) break;
      end
      if (FT[k][8]) chk("fetch", {2'b01, FT[k][7:0]}, d[9:0]);
      else chk("fetch refused", 1, d[DDATA_ERR]);
    end
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", 33'h100000000, {e, d});
    // Broken type byte on the serial string, slow memory during reload
    eepc_ee_model_inst.mem[9'h03f] = 8'h02;
    slow <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b1, REG_DSEL, 32'h0);
    apb(1'b0, REG_DDATA, 32'h0);
    chk("fetch while busy", 1, d[DDATA_ERR]);
    wait_load();
    chk("status strfail", 32'h01e70403, d);
    // Missing signature
    eepc_ee_model_inst.mem[0] = 8'h5a;
    slow <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h1);
    wait_load();
    chk("status nosig", 32'h00000001, d);
    chk("cfg default", 0, {image_valid, usb_disconnect, cfg});
    stop_test();
  end
endmodule : tb_eepc_loader
`default_nettype wire
